// >>> hw/mrt_pkg.sv
package mrt_pkg;
	localparam int MRT_W = 16;                     // Counter width
	localparam int MRT_PW = 4;                     // Prescale select width
	localparam logic [15:0] MRT_MIN = 16'h0000;     // Lowest count
	localparam logic [15:0] MRT_MAX = 16'hFFFF;     // Highest count
	localparam logic [15:0] MRT_CNT_RST = 16'h0000; // Count reset value
	localparam logic [3:0] MRT_PS_RST = 4'h0;       // Prescaler reset value
	localparam logic [3:0] MRT_BAUD_DIV = 4'hF;     // Sixteen overflows per bit
	// Count mode codes
	typedef enum logic [1:0] {
		MRT_CM_STD = 2'b00,
		MRT_CM_TOP = 2'b01,
		MRT_CM_DS1 = 2'b10,
		MRT_CM_DS2 = 2'b11
	} mrt_mode_e;
	// Configuration bundle
	typedef struct packed {
		logic runControl;
		logic counterTimerSelect;
		logic externalEventEnable;
		logic downCountEnable;
		logic txBaudSelect;
		logic rxBaudSelect;
		logic clockOutEnable;
		mrt_mode_e countModeSelect;
		logic [3:0] prescaleSelect;
	} mrt_cfg_s;
	// Flag bundle
	typedef struct packed {
		logic overflowFlag;
		logic externalFlag;
	} mrt_flags_s;
endpackage : mrt_pkg

// >>> hw/mrt_prescaler.sv
`timescale 1ns/100ps
// Issues one tick every prescale+1 enabled cycles
module mrt_prescaler (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic run,
	input wire logic [mrt_pkg::MRT_PW-1:0] prescaleSelect,
	output logic tick
);
	import mrt_pkg::*;
	logic [MRT_PW-1:0] div_reg; // Divider count
	wire divDone = (div_reg >= prescaleSelect); // Terminal count
	// Divider restarts when stopped so first step is a full period
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_reg <= MRT_PS_RST;
			tick <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				div_reg <= MRT_PS_RST;
				tick <= 1'b0;
			end else begin
				div_reg <= divDone ? MRT_PS_RST : div_reg + 1'b1;
				tick <= divDone;
			end
		end
	end
endmodule : mrt_prescaler

// >>> hw/mrt_pin_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser with falling-edge detect on the stable stage
module mrt_pin_sync (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic pinIn,
	output logic level,
	output logic fall
);
	logic meta_reg; // First stage, read only by the second
	logic sync_reg; // Second stage
	logic last_reg; // Previous stable sample
	// Pin idles high; reset to 1 avoids a false fall
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			last_reg <= 1'b1;
		end else if (ce) begin
			meta_reg <= pinIn;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end
	assign level = sync_reg;
	assign fall = last_reg & ~sync_reg;
endmodule : mrt_pin_sync

// >>> hw/multimode_reload_timer.sv
`timescale 1ns/100ps
// Timer core: capture, reload, dual slope, baud and clock out
module multimode_reload_timer (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire mrt_pkg::mrt_cfg_s cfg,
	input wire logic captureMode,
	input wire logic countWrEn,
	input wire logic [15:0] countWrData,
	input wire logic reloadWrEn,
	input wire logic [15:0] reloadWrData,
	input wire logic overflowClr,
	input wire logic externalClr,
	input wire logic externalTriggerPin,
	output logic [15:0] countValue,
	output logic [15:0] reloadCapture,
	output mrt_pkg::mrt_flags_s flags,
	output logic timerIrq,
	output logic baudTick,
	output logic clockOutPin,
	output logic clockOutOe,
	output logic downCountEnableOut
);
	import mrt_pkg::*;

	logic [15:0] cnt_reg;     // Live count
	logic [15:0] cap_reg;     // Reload/capture value seen by software
	logic [15:0] top_reg;     // Active TOP, double-buffered copy
	logic ovf_reg;            // Overflow flag
	logic ext_reg;            // External flag
	logic down_count_enable_reg;           // Latched down-count enable
	logic clk_out_reg;        // Clock-out pin level
	logic [3:0] baud_reg;     // Overflow divider for serial bit rate
	logic baud_tick_reg;      // Serial bit-rate pulse
	logic irq_reg;            // Interrupt request
	logic dsDown_reg;         // Dual slope direction, 1 while down
	logic tick;               // Prescaled step
	logic trigLevel;          // Synced trigger level
	logic trigFall;           // Synced trigger falling edge

	mrt_prescaler u_pre (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.run(cfg.runControl),
		.prescaleSelect(cfg.prescaleSelect),
		.tick(tick)
	);

	mrt_pin_sync u_sync (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.pinIn(externalTriggerPin),
		.level(trigLevel),
		.fall(trigFall)
	);

	// Mode decode
	wire baudMode = cfg.txBaudSelect | cfg.rxBaudSelect;
	wire dualSlope = ~baudMode & ~captureMode &
		cfg.countModeSelect[1];
	wire topMode = cfg.countModeSelect == MRT_CM_TOP;
	// Direction pin only counts with down-count and event enable
	wire updn = ~baudMode & ~captureMode & ~dualSlope & down_count_enable_reg &
		cfg.externalEventEnable;
	wire goDown = updn & ~trigLevel;
	wire extEvent = trigFall & cfg.externalEventEnable;
	// Overflow/underflow conditions
	wire upLimit = topMode & ~captureMode & ~baudMode ?
		(cnt_reg == top_reg) : (cnt_reg == MRT_MAX);
	wire dnLimit = topMode ? (cnt_reg == MRT_MIN) :
		(cnt_reg == cap_reg);
	wire dsTop = dualSlope & ~dsDown_reg & (cnt_reg == top_reg);
	wire dsMin = dualSlope & dsDown_reg & (cnt_reg == MRT_MIN);
	wire rollUp = tick & ~dualSlope & ~goDown & upLimit;
	wire rollDn = tick & goDown & dnLimit;
	wire roll = rollUp | rollDn;
	// Flag-set terms; dual slope mode 11 flags at TOP too
	wire ovfSet = ~baudMode & (roll | (tick & dsMin) |
		(tick & dsTop & (cfg.countModeSelect == MRT_CM_DS2)));
	wire dsToggleTop = tick & dsTop;
	wire dsTurnMin = tick & dsMin;
	wire anyOvf = roll | dsToggleTop | dsTurnMin;
	// Trigger actions per mode
	wire capEvt = captureMode & ~baudMode & extEvent;
	wire rldEvt = ~captureMode & ~baudMode & ~updn & ~dualSlope &
		~topMode & extEvent;
	wire clrEvt = ~captureMode & ~baudMode & ~updn & ~dualSlope &
		topMode & extEvent;
	// Flag event pulses that may interrupt
	wire extSetEvt = extEvent & ~updn & ~dualSlope;
	wire clkOutOn = cfg.clockOutEnable & ~cfg.counterTimerSelect;

	// Next count
	logic [15:0] cnt_next;
	always_comb begin
		cnt_next = cnt_reg;
		if (countWrEn)
			cnt_next = countWrData;
		else if (rldEvt)
			cnt_next = cap_reg;
		else if (clrEvt)
			cnt_next = MRT_MIN;
		else if (tick) begin
			if (dualSlope) begin
				if (dsTop | (dsDown_reg & ~dsMin))
					cnt_next = cnt_reg - 1'b1;
				else
					cnt_next = cnt_reg + 1'b1;
			end else if (captureMode & ~baudMode)
				cnt_next = cnt_reg + 1'b1;
			else if (rollUp)
				cnt_next = topMode & ~baudMode ? MRT_MIN : cap_reg;
			else if (rollDn)
				cnt_next = topMode ? top_reg : MRT_MAX;
			else if (goDown)
				cnt_next = cnt_reg - 1'b1;
			else
				cnt_next = cnt_reg + 1'b1;
		end
	end

	// Count and reload/capture register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= MRT_CNT_RST;
			cap_reg <= MRT_CNT_RST;
		end else if (ce) begin
			cnt_reg <= cnt_next;
			if (capEvt)
				cap_reg <= cnt_reg;
			else if (reloadWrEn)
				cap_reg <= reloadWrData;
		end
	end

	// TOP shadow: loads at any roll outside dual slope, at MIN (dual slope) or while stopped
	wire topLoad = (~dualSlope & roll) | dsTurnMin | ~cfg.runControl;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			top_reg <= MRT_CNT_RST;
		else if (ce && topLoad)
			top_reg <= cap_reg;
	end

	// Dual slope direction state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			dsDown_reg <= 1'b0;
		else if (ce) begin
			if (!dualSlope)
				dsDown_reg <= 1'b0;
			else if (dsToggleTop)
				dsDown_reg <= 1'b1;
			else if (dsTurnMin)
				dsDown_reg <= 1'b0;
		end
	end

	// Flags: hardware set wins over software clear
	logic ext_next;
	always_comb begin
		ext_next = ext_reg;
		if (externalClr)
			ext_next = 1'b0;
		if (dualSlope)
			ext_next = dsToggleTop | (dsDown_reg & ~dsTurnMin);
		else if (updn & roll)
			ext_next = ~ext_reg;
		else if (extSetEvt)
			ext_next = 1'b1;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ovf_reg <= 1'b0;
			ext_reg <= 1'b0;
		end else if (ce) begin
			ovf_reg <= ovfSet | (ovf_reg & ~overflowClr);
			ext_reg <= ext_next;
		end
	end

	// Interrupt: flag set events, but none for clock-out or baud rolls
	wire irqOvf = ovf_reg & ~baudMode & ~clkOutOn;
	wire irqExt = ext_reg & ~updn & ~dualSlope;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			irq_reg <= 1'b0;
		else if (ce)
			irq_reg <= irqOvf | irqExt;
	end

	// Down-count enable latch, cleared by reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			down_count_enable_reg <= 1'b0;
		else if (ce)
			down_count_enable_reg <= cfg.downCountEnable;
	end

	// Clock out toggles every roll; shares reload with baud
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			clk_out_reg <= 1'b0;
		else if (ce) begin
			if (clkOutOn && anyOvf)
				clk_out_reg <= ~clk_out_reg;
		end
	end

	// Serial bit rate: one pulse per sixteen overflows
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			baud_reg <= 4'h0;
			baud_tick_reg <= 1'b0;
		end else if (ce) begin
			baud_tick_reg <= baudMode & roll & (baud_reg == MRT_BAUD_DIV);
			if (baudMode && roll)
				baud_reg <= baud_reg + 1'b1;
		end
	end

	// Output registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clockOutOe <= 1'b0;
			downCountEnableOut <= 1'b0;
		end else if (ce) begin
			clockOutOe <= clkOutOn;
			downCountEnableOut <= down_count_enable_reg;
		end
	end
	assign countValue = cnt_reg;
	assign reloadCapture = cap_reg;
	assign flags = '{overflowFlag: ovf_reg, externalFlag: ext_reg};
	assign timerIrq = irq_reg;
	assign baudTick = baud_tick_reg;
	assign clockOutPin = clk_out_reg;

	// Checks
	AST_CAP_OVF: assert property (@(posedge clk) disable iff (!nrst)
		ce && tick && captureMode && !baudMode && cnt_reg == MRT_MAX &&
		!countWrEn
		|=> ovf_reg && cnt_reg == MRT_MIN)
		else $error("capture wrap missing flag");
	AST_CAP_COPY: assert property (@(posedge clk) disable iff (!nrst)
		ce && capEvt |=> cap_reg == $past(cnt_reg) && ext_reg)
		else $error("capture copy wrong");
	AST_DOWN_COUNT_ENABLE_RST: assert property (@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> !down_count_enable_reg)
		else $error("down enable not cleared");
	AST_RELOAD00: assert property (@(posedge clk) disable iff (!nrst)
		ce && rollUp && !topMode && !countWrEn && !rldEvt
		|=> cnt_reg == $past(cap_reg))
		else $error("bottom reload wrong");
	AST_CLR01: assert property (@(posedge clk) disable iff (!nrst)
		ce && clrEvt && !countWrEn |=> cnt_reg == MRT_MIN && ext_reg)
		else $error("trigger clear wrong");
	AST_BAUD_NOFLAG: assert property (@(posedge clk) disable iff (!nrst)
		ce && baudMode && roll && !ovf_reg |=> !ovf_reg)
		else $error("baud roll set flag");
	AST_UPDN_TGL: assert property (@(posedge clk) disable iff (!nrst)
		ce && updn && roll && !dualSlope |=> ext_reg != $past(ext_reg))
		else $error("17th bit not toggled");
	AST_CLKOUT: assert property (@(posedge clk) disable iff (!nrst)
		ce && clkOutOn && anyOvf |=> clockOutPin != $past(clockOutPin))
		else $error("clock out missed toggle");
	AST_DS_DIR: assert property (@(posedge clk) disable iff (!nrst)
		ce && dualSlope && !externalClr |=> ext_reg == dsDown_reg)
		else $error("direction flag wrong");
	// Mode 11 flags at TOP as well as at MIN
	AST_DS2_TOP: assert property (@(posedge clk) disable iff (!nrst)
		ce && dsToggleTop && cfg.countModeSelect == MRT_CM_DS2 |=> ovf_reg)
		else $error("mode 11 top flag missing");
	// Mode 10 stays quiet at TOP
	AST_DS1_TOP: assert property (@(posedge clk) disable iff (!nrst)
		ce && dsToggleTop && cfg.countModeSelect == MRT_CM_DS1 &&
		!ovf_reg |=> !ovf_reg)
		else $error("mode 10 flagged at top");
	// Shadow TOP only moves on its load condition
	AST_TOP_HOLD: assert property (@(posedge clk) disable iff (!nrst)
		ce && !topLoad |=> top_reg == $past(top_reg))
		else $error("top shadow moved early");
	// Down count past BOTTOM reloads MAX and flags
	AST_UNDER00: assert property (@(posedge clk) disable iff (!nrst)
		ce && rollDn && !topMode && !countWrEn
		|=> cnt_reg == MRT_MAX && ovf_reg)
		else $error("bottom underflow wrong");
	// Sixteenth baud roll gives the bit-rate pulse
	AST_BAUD_DIV: assert property (@(posedge clk) disable iff (!nrst)
		ce && baudMode && roll && baud_reg == MRT_BAUD_DIV |=> baudTick)
		else $error("baud pulse missing");
	// Direction flag never requests service
	AST_EXT_NOIRQ: assert property (@(posedge clk) disable iff (!nrst)
		ce && (updn || dualSlope) && !irqOvf |=> !timerIrq)
		else $error("direction flag raised request");
	COV_CAPTURE: cover property (@(posedge clk) capEvt);
	COV_DS_TOP: cover property (@(posedge clk) dsToggleTop);
	COV_UNDER: cover property (@(posedge clk) rollDn);
	COV_BAUD: cover property (@(posedge clk) baud_tick_reg);
endmodule : multimode_reload_timer

// >>> tb/mrt_trig_model.sv
`timescale 1ns/100ps
// Outside source on the trigger pin; moves just after the clock edge
module mrt_trig_model (
	input wire logic clk,
	input wire logic wantLevel,
	output logic pinOut
);
	// Idles high like a pulled-up input
	initial pinOut = 1'b1;
	// Follow the request after the edge, never in mid-cycle
	always @(posedge clk) begin
		pinOut <= #1 wantLevel;
	end
endmodule : mrt_trig_model

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import mrt_pkg::*;
	logic clk = 1'b0; // 250 MHz
	logic nrst = 1'b0; // Active low reset
	mrt_cfg_s cfg = '0; // Configuration bits
	logic captureMode = 1'b0;
	logic countWrEn = 1'b0;
	logic [15:0] countWrData = 16'h0000;
	logic reloadWrEn = 1'b0;
	logic [15:0] reloadWrData = 16'h0000;
	logic flagClr = 1'b0; // Drives both flag clears
	logic wantLevel = 1'b1; // Requested trigger level
	logic pin;
	logic [15:0] countValue;
	logic [15:0] reloadCapture;
	mrt_flags_s flags;
	logic timerIrq;
	logic baudTick; // Bit-rate pulse
	int nb; // Pulse counter
	logic clockOutPin;
	logic clockOutOe;
	logic dcenOut;
	int err_count = 0;
	int samples_checked = 0;
	int seed = 32'hC5C5;
	int i;
	logic [15:0] r; // Random operand
	logic [17:0] expQ[$]; // Expected notes
	logic [17:0] seenQ[$]; // Matching observations
	// Half period of 2 ns
	always #2 clk = ~clk;
	multimode_reload_timer multimode_reload_timer_inst (.clk(clk),
		.nrst(nrst), .ce(1'b1), .cfg(cfg), .captureMode(captureMode),
		.countWrEn(countWrEn), .countWrData(countWrData),
		.reloadWrEn(reloadWrEn), .reloadWrData(reloadWrData),
		.overflowClr(flagClr), .externalClr(flagClr),
		.externalTriggerPin(pin), .countValue(countValue),
		.reloadCapture(reloadCapture), .flags(flags),
		.timerIrq(timerIrq), .baudTick(baudTick),
		.clockOutPin(clockOutPin),
		.clockOutOe(clockOutOe), .downCountEnableOut(dcenOut));
	mrt_trig_model mrt_trig_model_inst (.clk(clk), .wantLevel(wantLevel),
		.pinOut(pin));
	// Single comparison point
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Driver side: queue what was seen with what should be
	task automatic note(input logic [17:0] seen, input logic [17:0] exp);
		seenQ.push_back(seen);
		expQ.push_back(exp);
	endtask : note
	// Monitor drains notes oldest first, away from the sampling edge
	always @(negedge clk) begin
		while (expQ.size() > 0) check(seenQ.pop_front(), expQ.pop_front());
	end
	// Inputs always move 1 ns after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	// Bounded wait for a count value; a hang ends the run
	task automatic wait_cnt(input logic [15:0] t);
		for (int k = 0; k < 300 && countValue !== t; k++) step(1);
		if (countValue !== t) begin
			err_count++;
			give_verdict();
		end
	endtask : wait_cnt
	// Stop, load count and reload together and clear flags, all in the same cycle
	task automatic load(input logic [15:0] c, input logic [15:0] rl);
		cfg.runControl = 1'b0;
		countWrData = c;
		reloadWrData = rl;
		countWrEn = 1'b1;
		reloadWrEn = 1'b1;
		flagClr = 1'b1;
		step(1);
		countWrEn = 1'b0;
		reloadWrEn = 1'b0;
		flagClr = 1'b0;
		step(1);
	endtask : load
	task automatic give_verdict();
		step(2);
		$display("Checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		#1 nrst = 1'b1;
		step(1);
		note({17'h0, dcenOut}, 18'h0);
		// Capture mode wrap, then trigger with enable off and on
		captureMode = 1'b1;
		load(16'hFFFE, 16'h0000);
		cfg.runControl = 1'b1;
		wait_cnt(16'h0001);
		note({flags, countValue}, {2'b10, 16'h0001});
		step(1);
		note({17'h0, timerIrq}, 18'h1);
		for (i = 0; i < 2; i++) begin
			r = 16'($random(seed));
			load(r, 16'h0000);
			cfg.externalEventEnable = i[0];
			wantLevel = 1'b0;
			step(8);
			note({1'b0, flags.externalFlag, i[0] ? reloadCapture : 16'h0},
				{1'b0, i[0], i[0] ? r : 16'h0});
			wantLevel = 1'b1;
			step(4);
		end
		// Random prescale: cycles between steps
		cfg.externalEventEnable = 1'b0;
		cfg.prescaleSelect = 4'($random(seed));
		load(16'h0000, 16'h0000);
		cfg.runControl = 1'b1;
		wait_cnt(16'h0001);
		for (i = 0; i < 40 && countValue === 16'h0001; i++) step(1);
		note(18'(i), 18'(cfg.prescaleSelect) + 18'h1);
		// Mode 00 up: reload BOTTOM on overflow
		cfg.prescaleSelect = 4'h0;
		captureMode = 1'b0;
		r = 16'($random(seed)) & 16'h7FFF;
		load(16'hFFFD, r);
		cfg.runControl = 1'b1;
		wait_cnt(r);
		note({flags, countValue}, {2'b10, r});
		// Mode 01 up: TOP then MIN
		cfg.countModeSelect = MRT_CM_TOP;
		load(16'h0000, 16'h0005);
		cfg.runControl = 1'b1;
		wait_cnt(16'h0005);
		step(1);
		note({flags, countValue}, {2'b10, 16'h0000});
		// Mode 00 down with pin low: underflow at BOTTOM to MAX
		cfg.countModeSelect = MRT_CM_STD;
		wantLevel = 1'b0;
		step(6);
		cfg.externalEventEnable = 1'b1;
		cfg.downCountEnable = 1'b1;
		load(16'h0012, 16'h0010);
		cfg.runControl = 1'b1;
		wait_cnt(16'hFFFF);
		note({flags, countValue}, {2'b11, 16'hFFFF});
		// Dual slope single update: descending, no flag at TOP
		cfg.externalEventEnable = 1'b0;
		cfg.countModeSelect = MRT_CM_DS1;
		load(16'h0000, 16'h0003);
		cfg.runControl = 1'b1;
		wait_cnt(16'h0003);
		wait_cnt(16'h0002);
		note({flags, countValue}, {2'b01, 16'h0002});
		// Clock out: pin enabled, rollovers raise no request
		cfg.downCountEnable = 1'b0;
		cfg.countModeSelect = MRT_CM_STD;
		cfg.clockOutEnable = 1'b1;
		load(16'hFFFF, 16'hFFFE);
		note({17'h0, clockOutOe}, 18'h1);
		cfg.runControl = 1'b1;
		step(6);
		note({16'h0, timerIrq, flags.overflowFlag}, 18'h1);
		note({17'h0, clockOutPin}, 18'h1);
		// Baud mode: reload every step, pulse per sixteen rolls
		cfg.clockOutEnable = 1'b0;
		cfg.txBaudSelect = 1'b1;
		load(16'hFFFF, 16'hFFFF);
		cfg.runControl = 1'b1;
		nb = 0;
		for (i = 0; i < 80; i++) begin
			step(1);
			if (baudTick === 1'b1)
				nb++;
		end
		note(18'(nb), 18'h4);
		note({16'h0, flags}, 18'h0);
		give_verdict();
	end
endmodule : tb_top
